/* abp_adc_engine.sv */
`timescale 1ns/1ns
`include "abp_map.svh"
// successive-approximation sequencer with a digital stand-in comparator
module abp_adc_engine
  import abp_pkg::*;
#(
  parameter int RES_W = 12
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire abp_ctrl_type ctrl,
  input  wire logic [RES_W-1:0] analog_code,
  output abp_stat_type      stat,
  output logic              done_pulse,
  output logic              cal_done_pulse
);
  abp_state_type     state_q, state_d;
  logic [15:0]       cnt_q, cnt_d;
  logic [7:0]        div_q, div_d;
  logic [4:0]        bit_q, bit_d;
  logic [RES_W-1:0]  sar_q, sar_d;
  logic [RES_W-1:0]  res_q, res_d;
  logic              valid_q, valid_d;

  // next state of the sequencer
  always_comb begin
    state_d        = state_q;
    cnt_d          = cnt_q;
    div_d          = div_q;
    bit_d          = bit_q;
    sar_d          = sar_q;
    res_d          = res_q;
    valid_d        = valid_q;
    done_pulse     = 1'b0;
    cal_done_pulse = 1'b0;
    unique case (state_q)
      ST_CAL: begin
        cnt_d = cnt_q + 16'd1;
        if (cnt_q == `ABP_CAL_CYCLES - 16'd1) begin
          state_d        = ST_IDLE;
          cal_done_pulse = 1'b1;
        end
      end
      ST_IDLE: begin
        // start accepted only outside power-down
        if (ctrl.start && !ctrl.power_down) begin
          state_d = ST_SAMPLE;
          cnt_d   = 16'd0;
          valid_d = 1'b0;
        end
      end
      ST_SAMPLE: begin
        cnt_d = cnt_q + 16'd1;
        if (cnt_q[7:0] >= ctrl.sample_time) begin
          state_d = ST_CONVERT;
          bit_d   = 5'(RES_W - 1);
          sar_d   = '0;
          div_d   = 8'd0;
        end
      end
      ST_CONVERT: begin
        // each bit takes clock_divide+1 cycles; comparator halts in power-down
        if (!ctrl.power_down) begin
          div_d = div_q + 8'd1;
          if (div_q >= ctrl.clock_divide) begin
            div_d = 8'd0;
            sar_d = sar_q | (analog_code & (RES_W'(1) << bit_q));
            if (bit_q == 5'd0) begin
              state_d = ST_DONE;
            end else begin
              bit_d = bit_q - 5'd1;
            end
          end
        end
      end
      ST_DONE: begin
        res_d      = sar_q;
        valid_d    = 1'b1;
        done_pulse = 1'b1;
        state_d    = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    // converter reset dominates while held
    if (ctrl.reset) begin
      state_d = ST_IDLE;
      valid_d = 1'b0;
      cnt_d   = 16'd0;
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_CAL;
      cnt_q   <= 16'd0;
      div_q   <= 8'd0;
      bit_q   <= 5'd0;
      sar_q   <= '0;
      res_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      div_q   <= div_d;
      bit_q   <= bit_d;
      sar_q   <= sar_d;
      res_q   <= res_d;
      valid_q <= valid_d;
    end
  end

  // status flags
  assign stat.busy         = (state_q == ST_SAMPLE) || (state_q == ST_CONVERT)
                             || (state_q == ST_DONE);
  assign stat.calibrate    = (state_q == ST_CAL);
  assign stat.sample       = (state_q == ST_SAMPLE);
  assign stat.result_valid = valid_q;
  assign stat.result       = res_q;
endmodule

/* abp_analog_block.sv */
`timescale 1ns/1ns
`include "abp_map.svh"
module abp_analog_block
  import abp_pkg::*;
#(
  parameter int QUADS   = 10,
  parameter int MON_DEP = 256
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [11:0] analog_code,
  output logic             conv_reference_pin_o,
  output logic             conv_reference_pin_oe,
  input  wire logic        conv_reference_pin_i,
  input  wire logic        conv_ground_reference,
  output logic             external_reference_used,
  output logic [QUADS-1:0] quad_enable,
  output logic [QUADS-1:0] current_monitor_strobe,
  output logic             internal_temp_strobe,
  input  wire logic        monitor_port_clock,
  input  wire logic        monitor_port_reset_n,
  input  wire logic        monitor_port_write_enable,
  input  wire logic [7:0]  monitor_port_address,
  input  wire logic [7:0]  monitor_port_write_data,
  output logic [7:0]       monitor_port_read_data
);
  // ************************************************************
  // register state
  // ************************************************************
  logic [15:0]       ctrl_q, ctrl_d;
  logic [15:0]       conv_q, conv_d;
  logic [`ABP_IRQ_W-1:0] ist_q, ist_d;
  logic [`ABP_IRQ_W-1:0] imask_q, imask_d;
  logic [QUADS:0]    stb_q, stb_d;
  logic [1:0]        gap_q, gap_d;
  logic              start_q, start_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              slverr_q, slverr_d;
  abp_ctrl_type      ctrl;
  abp_stat_type      stat;
  logic              done_pulse;
  logic              cal_done_pulse;
  logic              wr_acc;
  logic              rd_acc;

  // true when the byte address hits a mapped register
  function automatic logic addr_hit(input logic [11:0] a);
    return (a == `ABP_OFF_CTRL) || (a == `ABP_OFF_CONV) || (a == `ABP_OFF_STATUS)
        || (a == `ABP_OFF_RESULT) || (a == `ABP_OFF_IRQ_STAT)
        || (a == `ABP_OFF_IRQ_MASK) || (a == `ABP_OFF_STROBE);
  endfunction

  // ************************************************************
  // apb slave: zero wait states, error on unmapped address
  // ************************************************************
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !pwrite && !penable;
  assign prdata  = rdata_q;
  assign pslverr = slverr_q && psel && penable;

  // read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    rdata_d  = rdata_q;
    slverr_d = 1'b0;
    if (psel && !penable) begin
      slverr_d = !addr_hit(paddr);
    end
    if (rd_acc) begin
      unique case (paddr)
        `ABP_OFF_CTRL:     rdata_d = {16'h0000, ctrl_q};
        `ABP_OFF_CONV:     rdata_d = {16'h0000, conv_q};
        `ABP_OFF_STATUS:   rdata_d = {28'h0000000, stat.sample, stat.result_valid,
                                      stat.calibrate, stat.busy};
        `ABP_OFF_RESULT:   rdata_d = {20'h00000, stat.result};
        `ABP_OFF_IRQ_STAT: rdata_d = {30'h00000000, ist_q};
        `ABP_OFF_IRQ_MASK: rdata_d = {30'h00000000, imask_q};
        `ABP_OFF_STROBE:   rdata_d = {21'h000000, stb_q};
        default:           rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  // ************************************************************
  // control, strobes, start pacing
  // ************************************************************
  always_comb begin
    ctrl_d  = ctrl_q;
    conv_d  = conv_q;
    imask_d = imask_q;
    stb_d   = '0;         // strobes are one-cycle pulses
    start_d = 1'b0;
    gap_d   = (gap_q != 2'd0) ? gap_q - 2'd1 : 2'd0;
    // hold off the next start one clock after a result
    if (done_pulse) begin
      gap_d = `ABP_GAP_CYCLES;
    end
    if (wr_acc) begin
      unique case (paddr)
        `ABP_OFF_CTRL: begin
          ctrl_d = pwdata[15:0];
          ctrl_d[`ABP_CTRL_START] = 1'b0;
          start_d = pwdata[`ABP_CTRL_START] && (gap_q == 2'd0) && !done_pulse;
        end
        `ABP_OFF_CONV:     conv_d  = pwdata[15:0];
        `ABP_OFF_IRQ_MASK: imask_d = pwdata[`ABP_IRQ_W-1:0];
        `ABP_OFF_STROBE:   stb_d   = pwdata[QUADS:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 16'h0000;
      conv_q  <= 16'h0000;
      imask_q <= '0;
      stb_q   <= '0;
      start_q <= 1'b0;
      gap_q   <= 2'd0;
    end else begin
      ctrl_q  <= ctrl_d;
      conv_q  <= conv_d;
      imask_q <= imask_d;
      stb_q   <= stb_d;
      start_q <= start_d;
      gap_q   <= gap_d;
    end
  end

  // engine controls; mode and timing only change by software write
  always_comb begin
    ctrl.start        = start_q;
    ctrl.power_down   = ctrl_q[`ABP_CTRL_PWRDN];
    ctrl.reset        = ctrl_q[`ABP_CTRL_CRST];
    ctrl.ref_select   = ctrl_q[`ABP_CTRL_REFSEL];
    ctrl.mode         = ctrl_q[`ABP_CTRL_MODE_LSB +: 4];
    ctrl.channel      = ctrl_q[`ABP_CTRL_CH_LSB +: 5];
    ctrl.clock_divide = conv_q[`ABP_CONV_DIV_LSB +: 8];
    ctrl.sample_time  = conv_q[`ABP_CONV_STC_LSB +: 8];
  end

  // ************************************************************
  // interrupts: set wins over write-one-to-clear
  // ************************************************************
  always_comb begin
    ist_d = ist_q;
    if (wr_acc && paddr == `ABP_OFF_IRQ_STAT) begin
      ist_d = ist_q & ~pwdata[`ABP_IRQ_W-1:0];
    end
    if (done_pulse) begin
      ist_d[`ABP_IRQ_DONE] = 1'b1;
    end
    if (cal_done_pulse) begin
      ist_d[`ABP_IRQ_CALDONE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= ist_d;
    end
  end

  assign irq = |(ist_q & imask_q);

  // ************************************************************
  // pins driven from register bits
  // ************************************************************
  // internal reference drives the pin only when select is 0
  assign conv_reference_pin_o    = 1'b1;
  assign conv_reference_pin_oe   = !ctrl_q[`ABP_CTRL_REFSEL];
  assign external_reference_used = ctrl_q[`ABP_CTRL_REFSEL];
  // quads are disabled while converter reset is held
  assign quad_enable             = ctrl_q[`ABP_CTRL_CRST] ? '0 : '1;
  assign current_monitor_strobe  = stb_q[QUADS-1:0];
  assign internal_temp_strobe    = stb_q[`ABP_STB_TEMP];

  // ************************************************************
  // children
  // ************************************************************
  abp_adc_engine #(
    .RES_W(12)
  ) u_engine (
    .pclk           (pclk),
    .presetn        (presetn),
    .ctrl           (ctrl),
    .analog_code    (analog_code),
    .stat           (stat),
    .done_pulse     (done_pulse),
    .cal_done_pulse (cal_done_pulse)
  );

  abp_monitor_port #(
    .DEPTH(MON_DEP)
  ) u_monitor (
    .monitor_port_clock        (monitor_port_clock),
    .monitor_port_reset_n      (monitor_port_reset_n),
    .monitor_port_write_enable (monitor_port_write_enable),
    .monitor_port_address      (monitor_port_address),
    .monitor_port_write_data   (monitor_port_write_data),
    .monitor_port_read_data    (monitor_port_read_data)
  );
endmodule

/* abp_analog_block_chk.sv */
`timescale 1ns/1ns
`include "abp_map.svh"
// ******
// port checks of the analog block
// ******
module abp_analog_block_chk
  import abp_pkg::*;
#(
  parameter int QUADS = 10
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             conv_reference_pin_o,
  input wire logic             conv_reference_pin_oe,
  input wire logic             external_reference_used,
  input wire logic [QUADS-1:0] quad_enable,
  input wire logic [QUADS-1:0] current_monitor_strobe,
  input wire logic             internal_temp_strobe,
  input wire logic             monitor_port_reset_n,
  input wire logic [7:0]       monitor_port_read_data
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       wr;
  logic       rd;
  logic [8:0] cyc_q;
  logic [8:0] cyc_d;
  // completed apb accesses
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // cycles since reset release; saturates so it never wraps back into calibration
  always_comb begin
    cyc_d = cyc_q + {8'h00, ~&cyc_q};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 9'h000;
    end else begin
      cyc_q <= cyc_d;
    end
  end
  property p_quad;
    wr && paddr == `ABP_OFF_CTRL |=> quad_enable == {QUADS{!$past(pwdata[`ABP_CTRL_CRST])}};
  endproperty
  a_quad: assert property (p_quad) else $error("quad enable wrong");
  property p_ref;
    wr && paddr == `ABP_OFF_CTRL |=> external_reference_used == $past(pwdata[3])
      && conv_reference_pin_oe == !$past(pwdata[3]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_ref_pin;
    conv_reference_pin_oe |-> conv_reference_pin_o && !external_reference_used;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin wrong");
  property p_cur;
    wr && paddr == `ABP_OFF_STROBE |=> current_monitor_strobe == $past(pwdata[QUADS-1:0])
      ##1 current_monitor_strobe == '0;
  endproperty
  a_cur: assert property (p_cur) else $error("current strobe wrong");
  property p_temp;
    wr && paddr == `ABP_OFF_STROBE |=> internal_temp_strobe == $past(pwdata[10])
      ##1 !internal_temp_strobe;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature strobe wrong");
  property p_mon;
    !monitor_port_reset_n |-> monitor_port_read_data == 8'h00;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor port not in reset");
  property p_cal;
    rd && paddr == `ABP_OFF_STATUS && cyc_q < 9'd200 |-> prdata[`ABP_ST_CAL];
  endproperty
  a_cal: assert property (p_cal) else $error("calibration flag low");
  property p_sample;
    rd && paddr == `ABP_OFF_STATUS && prdata[`ABP_ST_SAMPLE] |-> prdata[`ABP_ST_BUSY]
      && !prdata[`ABP_ST_VALID] && !prdata[`ABP_ST_CAL];
  endproperty
  a_sample: assert property (p_sample) else $error("sample outside conversion");
endmodule
bind abp_analog_block abp_analog_block_chk #(.QUADS(QUADS)) u_abp_analog_block_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .conv_reference_pin_o, .conv_reference_pin_oe, .external_reference_used,
  .quad_enable, .current_monitor_strobe, .internal_temp_strobe,
  .monitor_port_reset_n, .monitor_port_read_data
);

/* abp_analog_block_tb.sv */
`timescale 1ns/1ns
`include "abp_map.svh"
`define CHK(n, e, s) begin \
  num_checks++; \
  if ((s) !== (e)) begin \
    error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, s); \
  end \
end
module abp_analog_block_tb
  import abp_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_v;
  logic        ref_o, ref_oe, ref_i, ext_ref, tmp_stb, mpc, mprst_n, mpwe;
  logic [11:0] paddr, analog_code;
  logic [31:0] pwdata, prdata, rd_v;
  logic [9:0]  quad_en, cur_stb;
  logic [7:0]  mpa, mpwd, mprd;
  int          error_cnt, num_checks;
  abp_analog_block u_abp_analog_block (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .analog_code, .conv_reference_pin_o(ref_o),
    .conv_reference_pin_oe(ref_oe), .conv_reference_pin_i(ref_i),
    .conv_ground_reference(1'b0), .external_reference_used(ext_ref),
    .quad_enable(quad_en), .current_monitor_strobe(cur_stb), .internal_temp_strobe(tmp_stb),
    .monitor_port_clock(mpc), .monitor_port_reset_n(mprst_n), .monitor_port_write_enable(mpwe),
    .monitor_port_address(mpa), .monitor_port_write_data(mpwd), .monitor_port_read_data(mprd)
  );
  abp_core_model u_core (
    .clk(mpc), .rst_n(mprst_n), .wen(mpwe), .addr(mpa), .wdata(mpwd), .rdata(mprd)
  );
  // reference pin: an outside source holds it high when the block lets go
  assign ref_i = ref_oe ? ref_o : 1'b1;
  always #10 pclk = ~pclk;
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one apb transfer; idle edge after it so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `ABP_OFF_STATUS, 32'h0);
      n++;
    end while (rd_v[b] !== v && n < 300);
    `CHK("status wait", v, rd_v[b])
  endtask
  task automatic conv(input logic [11:0] c, input logic [31:0] cv, input logic [31:0] ctl);
    analog_code <= c;
    apb(1'b1, `ABP_OFF_CONV, cv);
    apb(1'b1, `ABP_OFF_CTRL, ctl | 32'h1);
    // select 0 drives the reference out, 1 takes it from outside
    `CHK("ref sel", {!ctl[`ABP_CTRL_REFSEL], ctl[`ABP_CTRL_REFSEL]}, {ref_oe, ext_ref})
    apb(1'b0, `ABP_OFF_STATUS, 32'h0);
    `CHK("busy", 1'b1, rd_v[`ABP_ST_BUSY])
    wait_st(`ABP_ST_VALID, 1'b1);
    `CHK("idle", 1'b0, rd_v[`ABP_ST_BUSY])
    apb(1'b0, `ABP_OFF_RESULT, 32'h0);
    `CHK("result", {20'h0, c}, rd_v)
    `CHK("irq done", 1'b1, irq)
    apb(1'b1, `ABP_OFF_IRQ_STAT, 32'h3);
    `CHK("irq clear", 1'b0, irq)
  endtask
  initial begin
    #1000000;
    error_cnt++;
    finish_test();
  end
  initial begin
    logic [11:0] code;
    logic [31:0] ctl;
    logic [7:0]  ma, mv;
    logic [7:0]  md;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    analog_code = 12'h000;
    void'($urandom(53));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ABP_OFF_STATUS, 32'h0);
    `CHK("cal", 1'b1, rd_v[`ABP_ST_CAL])
    wait_st(`ABP_ST_CAL, 1'b0);
    apb(1'b0, `ABP_OFF_IRQ_STAT, 32'h0);
    `CHK("cal done", 2'b10, rd_v[1:0])
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, `ABP_OFF_IRQ_MASK, 32'h3);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, `ABP_OFF_IRQ_STAT, 32'h2);
    `CHK("irq off", 1'b0, irq)
    // extreme codes and fastest timing first, then random
    for (int i = 0; i < 6; i++) begin
      code = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
      ctl = {19'h0, 5'($urandom), 4'($urandom), i[0], 3'h0};
      conv(code, (i < 2) ? 32'h0 : {16'h0, 8'($urandom % 4), 8'($urandom % 4)}, ctl);
    end
    // power-down in mid conversion freezes it; registers stay reachable
    apb(1'b1, `ABP_OFF_CONV, 32'h0303);
    apb(1'b1, `ABP_OFF_CTRL, ctl | 32'h1);
    apb(1'b1, `ABP_OFF_CTRL, ctl | 32'h2);
    repeat (100) @(posedge pclk);
    apb(1'b0, `ABP_OFF_STATUS, 32'h0);
    `CHK("frozen", 2'b01, {rd_v[`ABP_ST_VALID], rd_v[`ABP_ST_BUSY]})
    apb(1'b1, `ABP_OFF_CTRL, ctl);
    wait_st(`ABP_ST_VALID, 1'b1);
    apb(1'b0, `ABP_OFF_RESULT, 32'h0);
    `CHK("resumed", {20'h0, code}, rd_v)
    // converter reset aborts a running conversion
    apb(1'b1, `ABP_OFF_CTRL, ctl | 32'h1);
    apb(1'b1, `ABP_OFF_CTRL, ctl | 32'h4);
    `CHK("quads off", 10'h000, quad_en)
    apb(1'b0, `ABP_OFF_STATUS, 32'h0);
    `CHK("aborted", 1'b0, rd_v[`ABP_ST_BUSY])
    apb(1'b1, `ABP_OFF_CTRL, ctl);
    `CHK("quads on", 10'h3ff, quad_en)
    apb(1'b1, `ABP_OFF_STROBE, 32'h7ff);
    apb(1'b1, `ABP_OFF_STROBE, 32'($urandom) & 32'h7ff);
    apb(1'b1, 12'h01c, 32'hffff_ffff);
    `CHK("slverr", 1'b1, err_v)
    apb(1'b0, 12'h01c, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err_v, rd_v})
    for (int i = 0; i < 4; i++) begin
      ma = (i == 0) ? 8'hff : 8'($urandom);
      md = 8'($urandom);
      u_core.mon_wr(ma, md);
      u_core.mon_rd(ma, mv);
      `CHK("monitor read", md, mv)
    end
    u_core.mon_rst();
    u_core.mon_rd(ma, mv);
    `CHK("monitor reset", 8'h00, mv)
    finish_test();
  end
endmodule

/* abp_core_model.sv */
`timescale 1ns/1ns
// ******
// user logic on the monitor configuration port, own free-running clock
// ******
module abp_core_model (
  output logic            clk,
  output logic            rst_n,
  output logic            wen,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;   // store starts cleared, not unknown
    wen = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  end
  // 30 ns period against the 20 ns pclk, so falling port-clock edges line up with pclk edges every 30 ns
  always #15 clk = ~clk;
  // one enabled cycle; data then turns over so a stale byte cannot pass
  task automatic mon_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wen <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wen <= 1'b0;
    wdata <= ~d;
  endtask
  // read data is registered one port clock after the address
  task automatic mon_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    d = rdata;
  endtask
  task automatic mon_rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
endmodule

/* abp_map.svh */
`ifndef ABP_MAP_SVH
`define ABP_MAP_SVH
// ************************************************************
// register offsets (byte addresses on apb)
// ************************************************************
`define ABP_OFF_CTRL      12'h000
`define ABP_OFF_CONV      12'h004
`define ABP_OFF_STATUS    12'h008
`define ABP_OFF_RESULT    12'h00c
`define ABP_OFF_IRQ_STAT  12'h010
`define ABP_OFF_IRQ_MASK  12'h014
`define ABP_OFF_STROBE    12'h018
// ************************************************************
// control register fields
// ************************************************************
`define ABP_CTRL_START    0
`define ABP_CTRL_PWRDN    1
`define ABP_CTRL_CRST     2
`define ABP_CTRL_REFSEL   3
`define ABP_CTRL_MODE_LSB 4
`define ABP_CTRL_CH_LSB   8
// conv register: divide [7:0], sample time [15:8]
`define ABP_CONV_DIV_LSB  0
`define ABP_CONV_STC_LSB  8
// status and interrupt bits
`define ABP_ST_BUSY       0
`define ABP_ST_CAL        1
`define ABP_ST_VALID      2
`define ABP_ST_SAMPLE     3
`define ABP_IRQ_DONE      0
`define ABP_IRQ_CALDONE   1
`define ABP_IRQ_W         2
// strobe register: current monitors [9:0], temperature [10]
`define ABP_STB_TEMP      10
// ************************************************************
// timing counts
// ************************************************************
`define ABP_CAL_CYCLES    16'd256
`define ABP_CONV_BITS     5'd12
`define ABP_GAP_CYCLES    2'd1
`endif

/* abp_monitor_port.sv */
`timescale 1ns/1ns
// byte-wide monitor configuration store on its own port clock
module abp_monitor_port #(
  parameter int DEPTH = 256
) (
  input  wire logic       monitor_port_clock,
  input  wire logic       monitor_port_reset_n,
  input  wire logic       monitor_port_write_enable,
  input  wire logic [7:0] monitor_port_address,
  input  wire logic [7:0] monitor_port_write_data,
  output logic [7:0]      monitor_port_read_data
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rd_d;

  // read data follows address
  always_comb begin
    rd_d = mem_q[monitor_port_address];
  end

  // held in reset while reset_n is low
  always_ff @(posedge monitor_port_clock or negedge monitor_port_reset_n) begin
    if (!monitor_port_reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
      monitor_port_read_data <= 8'h00;
    end else begin
      if (monitor_port_write_enable) begin
        mem_q[monitor_port_address] <= monitor_port_write_data;
      end
      monitor_port_read_data <= rd_d;
    end
  end
endmodule

/* abp_pkg.sv */
package abp_pkg;
  typedef enum logic [2:0] {
    ST_CAL,
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_DONE
  } abp_state_type;

  // converter controls as seen by the conversion engine
  typedef struct packed {
    logic       start;
    logic       power_down;
    logic       reset;
    logic       ref_select;
    logic [3:0] mode;
    logic [4:0] channel;
    logic [7:0] clock_divide;
    logic [7:0] sample_time;
  } abp_ctrl_type;

  // converter status flags
  typedef struct packed {
    logic        busy;
    logic        calibrate;
    logic        result_valid;
    logic        sample;
    logic [11:0] result;
  } abp_stat_type;
endpackage
